// *** hw/const_alu.sv ***
/*
 Combinational literal arithmetic on the working register: add, subtract
 from literal, logic ops and multiply, with the flag results.
*/
`timescale 1ns/1ps
`include "core_decode_params.svh"
module const_alu
(
  input core_decode_pkg::op_class_t op,
  input wire logic [7:0] w,
  input wire logic [7:0] k,
  output logic [7:0] result,
  output logic [15:0] product,
  output core_decode_pkg::alu_flags_t flags
);
  import core_decode_pkg::*;
  logic [8:0] sum;
  logic [4:0] half;
  logic [7:0] b;
  logic [7:0] a;
  always_comb
  begin
    // Subtract is k + ~w + 1, carry means no borrow
    a = k;
    b = (op == op_const_sub) ? ~w : w;
    sum = {1'b0, a} + {1'b0, b} + {8'h00, op == op_const_sub};
    half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, op == op_const_sub};
    flags = '0;
    result = w;
    unique case (op)
      op_const_add, op_const_sub:
      begin
        result = sum[7:0];
        flags.carry = sum[8];
        flags.digit_carry = half[4];
        flags.overflow = (a[7] == b[7]) && (sum[7] != a[7]);
      end
      op_const_and: result = w & k;
      op_const_or: result = w | k;
      op_const_xor: result = w ^ k;
      op_const_load: result = k;
      default: result = w;
    endcase
    flags.zero = (result == 8'h00);
    flags.negative = result[7];
  end
  assign product = w * k;
endmodule

// *** hw/instr_decode_core.sv ***
/*
 Instruction decoder and executor for the control, bit and literal groups of
 an 8-bit core. One instruction cycle per clk. Program memory returns the word
 at fetch_addr in the same cycle. The file-register path performs the actual
 register read and write; this block hands it address and new value.
*/
`timescale 1ns/1ps
`include "core_decode_params.svh"
// Summary of operation
// - Bit clear/set/toggle from top nibbles 1001/1000/0111; ports read pin levels.
// - Bit test skips next word when bit clear (1011) or set (1010); flags untouched.
// - Taken control transfer or true test costs two cycles; skipping two words, three.
// - Conditional branch 1110 0ccc with eight flag codes and 8-bit signed offset.
// - Absolute jump and call are two-word, two-cycle; call s bit saves context.
// - A lone second word executes as no-operation.
// - Interrupt return pops stack, re-enables both interrupt enables, two cycles.
// - Return with constant loads working register, pops stack, two cycles.
// - Push and pop of stack top take one cycle, no flag change.
// - Sleep enters standby in one cycle and updates timeout and powerdown flags.
// - Constant add and subtract write working register, update all five flags.
// - Constant and/or/xor take one cycle, update only zero and negative.
// - Constant load and multiply take one cycle, change no flags.
// - Bank load puts 4-bit constant into bank select bits 3..0.
// - Pointer load is two words: pointer select and top bits, then low byte.
// - Table read 0000 0000 0000 10mm, two cycles, four pointer modes.
// - Table write 0000 0000 0000 11mm, two cycles, four pointer modes.
// - A started program-memory write runs on until it terminates.
// - Bit modify on timer0 count clears an assigned prescaler.
module instr_decode_core
#(
  parameter int PC_W = 21,
  parameter int STACK_DEPTH = 31
)
(
  input wire logic clk,
  input wire logic reset,
  output logic [PC_W-1:0] fetch_addr,
  input wire logic [15:0] fetch_word,
  output logic [7:0] file_addr,
  output logic file_access_bank,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] pin_levels,
  output logic file_we,
  output logic [7:0] file_wdata,
  input wire logic prescaler_assigned,
  output logic prescaler_clear,
  output logic [7:0] working_register,
  output logic [3:0] bank_select_register,
  output core_decode_pkg::alu_flags_t status_flags,
  output logic [1:0] ptr_sel,
  output logic [11:0] ptr_value,
  output logic ptr_we,
  output logic [PC_W-1:0] table_ptr,
  output logic table_rd,
  output logic table_wr,
  input wire logic mem_write_busy,
  output logic [PC_W-1:0] stack_top,
  output logic context_save,
  output logic context_restore,
  output logic global_high_irq_enable,
  output logic peripheral_low_irq_enable,
  output logic [15:0] product,
  output logic standby,
  output logic timeout_flag,
  output logic powerdown_flag
);
  import core_decode_pkg::*;
  localparam int SP_W = $clog2(STACK_DEPTH + 1);
  op_class_t op;
  logic two_word;
  logic [7:0] alu_res;
  alu_flags_t alu_fl;
  logic [15:0] prod_w;
  seq_state_t st_q, st_d;
  logic [PC_W-1:0] pc_q, pc_d, tbl_q, tbl_d;
  logic [15:0] first_q, first_d;
  logic [7:0] w_q, w_d;
  logic [3:0] bank_q, bank_d;
  alu_flags_t fl_q, fl_d;
  logic [PC_W-1:0] stack_q [STACK_DEPTH];
  logic [SP_W-1:0] sp_q, sp_d;
  logic push_en, pop_en;
  logic [PC_W-1:0] push_val;
  logic gie_q, gie_d, pie_q, pie_d, sleep_q, sleep_d, to_q, to_d, pd_q, pd_d;
  logic [15:0] prod_q, prod_d;
  logic [7:0] src, modified;
  logic cond_true;
  logic [PC_W-1:0] pc_next;

  op_classify u_classify
  (
    .word(fetch_word),
    .op(op),
    .two_word(two_word)
  );
  const_alu u_alu
  (
    .op(op),
    .w(w_q),
    .k(fetch_word[7:0]),
    .result(alu_res),
    .product(prod_w),
    .flags(alu_fl)
  );

  function automatic logic is_port(input logic [7:0] a, input logic acc);
    is_port = !acc ? 1'b0 : (a >= `PORT_ADDR_LO && a <= `PORT_ADDR_HI);
  endfunction

  function automatic logic [PC_W-1:0] ptr_step(input logic [PC_W-1:0] p, input logic [1:0] m);
    ptr_step = (m == `MODE_POST_DEC) ? p - 1'b1 : (m == `MODE_NONE) ? p : p + 1'b1;
  endfunction

  assign pc_next = pc_q + 1'b1;
  assign fetch_addr = pc_q;
  assign file_addr = fetch_word[7:0];
  assign file_access_bank = fetch_word[8];

  always_comb
  begin
    unique case (fetch_word[10:8])
      3'h0: cond_true = fl_q.zero;
      3'h1: cond_true = !fl_q.zero;
      3'h2: cond_true = fl_q.carry;
      3'h3: cond_true = !fl_q.carry;
      3'h4: cond_true = fl_q.overflow;
      3'h5: cond_true = !fl_q.overflow;
      3'h6: cond_true = fl_q.negative;
      3'h7: cond_true = !fl_q.negative;
    endcase
  end

  always_comb
  begin
    src = is_port(fetch_word[7:0], fetch_word[8]) ? pin_levels : file_rdata;
    modified = src;
    unique case (op)
      op_bit_clear: modified[fetch_word[11:9]] = 1'b0;
      op_bit_set: modified[fetch_word[11:9]] = 1'b1;
      op_bit_toggle: modified[fetch_word[11:9]] = ~src[fetch_word[11:9]];
      default: modified = src;
    endcase
  end

  always_comb
  begin
    st_d = st_exec;
    pc_d = pc_next;
    tbl_d = tbl_q;
    first_d = first_q;
    w_d = w_q;
    bank_d = bank_q;
    fl_d = fl_q;
    sp_d = sp_q;
    push_en = 1'b0;
    pop_en = 1'b0;
    push_val = pc_next;
    gie_d = gie_q;
    pie_d = pie_q;
    sleep_d = sleep_q;
    to_d = to_q;
    pd_d = pd_q;
    prod_d = prod_q;
    file_we = 1'b0;
    file_wdata = modified;
    prescaler_clear = 1'b0;
    ptr_we = 1'b0;
    ptr_sel = first_q[5:4];
    ptr_value = {first_q[3:0], fetch_word[7:0]};
    table_rd = 1'b0;
    table_wr = 1'b0;
    context_save = 1'b0;
    context_restore = 1'b0;
    unique case (st_q)
      st_flush: pc_d = pc_q;
      st_skip2:
      begin
        pc_d = two_word ? PC_W'(pc_q + 2'd2) : pc_next;
        st_d = two_word ? st_flush : st_exec;
      end
      st_second:
      begin
        unique case (first_q[15:12] == `TOP_COND ? first_q[11:8] : 4'h0)
          `COND_ABS_JUMP: pc_d = PC_W'({fetch_word[11:0], first_q[7:0], 1'b0});
          `COND_PTR_LOAD: ptr_we = 1'b1;
          default:
          begin
            push_en = 1'b1;
            push_val = pc_next;
            context_save = first_q[8];
            pc_d = PC_W'({fetch_word[11:0], first_q[7:0], 1'b0});
          end
        endcase
        st_d = st_exec;
      end
      st_exec:
      begin
        if (sleep_q)
          pc_d = pc_q;
        else
        begin
          unique case (op)
            op_bit_clear, op_bit_set, op_bit_toggle:
            begin
              file_we = 1'b1;
              prescaler_clear = prescaler_assigned && fetch_word[7:0] == `TIMER0_COUNT_ADDR && fetch_word[8];
            end
            op_skip_clear, op_skip_set:
              if (src[fetch_word[11:9]] == (op == op_skip_set))
                st_d = st_skip2;
            op_cond_branch:
              if (cond_true)
              begin
                pc_d = PC_W'(pc_next + PC_W'({{(PC_W-9){fetch_word[7]}}, fetch_word[7:0], 1'b0}));
                st_d = st_flush;
              end
            op_rel_jump, op_rel_call:
            begin
              pc_d = PC_W'(pc_next + PC_W'({{(PC_W-12){fetch_word[10]}}, fetch_word[10:0], 1'b0}));
              push_en = (op == op_rel_call);
              st_d = st_flush;
            end
            op_abs_jump, op_abs_call, op_ptr_load:
            begin
              first_d = fetch_word;
              st_d = st_second;
            end
            op_irq_return, op_const_return:
            begin
              pop_en = 1'b1;
              pc_d = stack_top;
              st_d = st_flush;
              if (op == op_irq_return)
              begin
                gie_d = 1'b1;
                pie_d = 1'b1;
                context_restore = fetch_word[0];
              end
              else
                w_d = fetch_word[7:0];
            end
            op_push: push_en = 1'b1;
            op_pop: pop_en = 1'b1;
            op_sleep:
            begin
              sleep_d = 1'b1;
              to_d = 1'b1;
              pd_d = 1'b0;
            end
            op_const_add, op_const_sub:
            begin
              w_d = alu_res;
              fl_d = alu_fl;
            end
            op_const_and, op_const_or, op_const_xor:
            begin
              w_d = alu_res;
              fl_d.zero = alu_fl.zero;
              fl_d.negative = alu_fl.negative;
            end
            op_const_load: w_d = alu_res;
            op_const_mul: prod_d = prod_w;
            op_bank_load: bank_d = fetch_word[3:0];
            op_table_read, op_table_write:
            begin
              // A write still in progress holds the pointer so it runs on
              if (!(op == op_table_write && mem_write_busy))
              begin
                table_rd = (op == op_table_read);
                table_wr = (op == op_table_write);
                tbl_d = ptr_step(tbl_q, fetch_word[1:0]);
                st_d = st_flush;
              end
              else
                pc_d = pc_q;
            end
            default: pc_d = pc_next;
          endcase
        end
      end
    endcase
    if (push_en && sp_q < SP_W'(STACK_DEPTH))
      sp_d = sp_q + 1'b1;
    else if (pop_en && sp_q != '0)
      sp_d = sp_q - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_q <= st_exec;
      pc_q <= `PC_RESET;
      tbl_q <= `TBL_RESET;
      first_q <= 16'h0000;
      w_q <= `W_RESET;
      bank_q <= `BANK_RESET;
      fl_q <= `STATUS_RESET;
      sp_q <= '0;
      gie_q <= 1'b0;
      pie_q <= 1'b0;
      sleep_q <= 1'b0;
      to_q <= 1'b1;
      pd_q <= 1'b1;
      prod_q <= 16'h0000;
    end
    else
    begin
      st_q <= st_d;
      pc_q <= pc_d;
      tbl_q <= tbl_d;
      first_q <= first_d;
      w_q <= w_d;
      bank_q <= bank_d;
      fl_q <= fl_d;
      sp_q <= sp_d;
      gie_q <= gie_d;
      pie_q <= pie_d;
      sleep_q <= sleep_d;
      to_q <= to_d;
      pd_q <= pd_d;
      prod_q <= prod_d;
    end
  end

  // Stack array needs no reset; pointer alone defines contents
  always_ff @(posedge clk)
  begin
    if (!reset && push_en && sp_q < SP_W'(STACK_DEPTH))
      stack_q[sp_q] <= push_val;
  end

  assign stack_top = (sp_q == '0) ? '0 : stack_q[sp_q - 1'b1];
  assign table_ptr = (fetch_word[1:0] == `MODE_PRE_INC) ? tbl_q + 1'b1 : tbl_q;
  assign working_register = w_q;
  assign bank_select_register = bank_q;
  assign status_flags = fl_q;
  assign global_high_irq_enable = gie_q;
  assign peripheral_low_irq_enable = pie_q;
  assign product = prod_q;
  assign standby = sleep_q;
  assign timeout_flag = to_q;
  assign powerdown_flag = pd_q;
endmodule

// *** hw/op_classify.sv ***
/*
 Combinational classifier: maps a 16-bit instruction word to an operation
 class and reports whether the word opens a two-word instruction.
*/
`timescale 1ns/1ps
`include "core_decode_params.svh"
module op_classify
(
  input wire logic [15:0] word,
  output core_decode_pkg::op_class_t op,
  output logic two_word
);
  import core_decode_pkg::*;
  logic [3:0] top;
  logic [3:0] sub;
  assign top = word[15:12];
  assign sub = word[11:8];
  always_comb
  begin
    op = op_nop;
    unique case (top)
      `TOP_BIT_CLEAR: op = op_bit_clear;
      `TOP_BIT_SET: op = op_bit_set;
      `TOP_BIT_TOGGLE: op = op_bit_toggle;
      `TOP_SKIP_CLEAR: op = op_skip_clear;
      `TOP_SKIP_SET: op = op_skip_set;
      `TOP_REL: op = word[11] ? op_rel_call : op_rel_jump;
      `TOP_COND:
      begin
        if (sub[3] == 1'b0)
          op = op_cond_branch;
        else if (sub == `COND_ABS_JUMP)
          op = op_abs_jump;
        else if (sub == `COND_PTR_LOAD && word[7:6] == 2'h0)
          op = op_ptr_load;
        else if (sub[3:1] == `CALL_HI)
          op = op_abs_call;
      end
      `TOP_ZERO:
      begin
        unique case (sub)
          `LIT_ADD: op = op_const_add;
          `LIT_SUB: op = op_const_sub;
          `LIT_AND: op = op_const_and;
          `LIT_OR: op = op_const_or;
          `LIT_XOR: op = op_const_xor;
          `LIT_LOAD: op = op_const_load;
          `LIT_MUL: op = op_const_mul;
          `LIT_RET: op = op_const_return;
          `LIT_BANK: op = (word[7:4] == `BANK_HI) ? op_bank_load : op_nop;
          `LIT_MISC:
          begin
            if (word[7:0] == `MISC_SLEEP)
              op = op_sleep;
            else if (word[7:0] == `MISC_PUSH)
              op = op_push;
            else if (word[7:0] == `MISC_POP)
              op = op_pop;
            else if (word[7:1] == `MISC_IRET_HI)
              op = op_irq_return;
            else if (word[7:3] == `MISC_TABLE_HI)
              op = word[2] ? op_table_write : op_table_read;
          end
          default: op = op_nop;
        endcase
      end
      default: op = op_nop;
    endcase
  end
  assign two_word = (op == op_abs_jump) || (op == op_abs_call) || (op == op_ptr_load);
endmodule

// *** shared/core_decode_params.svh ***
/*
 Numeric constants for the instruction decoder: opcode fields, encodings,
 reset values, addresses and pointer modes. Included by the design modules.
*/
`ifndef CORE_DECODE_PARAMS_SVH
`define CORE_DECODE_PARAMS_SVH
`define TOP_BIT_CLEAR 4'h9
`define TOP_BIT_SET 4'h8
`define TOP_BIT_TOGGLE 4'h7
`define TOP_SKIP_CLEAR 4'hb
`define TOP_SKIP_SET 4'ha
`define TOP_REL 4'hd
`define TOP_COND 4'he
`define TOP_SECOND 4'hf
`define TOP_ZERO 4'h0
`define COND_ABS_JUMP 4'hf
`define COND_PTR_LOAD 4'he
`define CALL_HI 3'h6
`define LIT_ADD 4'hf
`define LIT_SUB 4'h8
`define LIT_AND 4'hb
`define LIT_OR 4'h9
`define LIT_XOR 4'ha
`define LIT_LOAD 4'he
`define LIT_MUL 4'hd
`define LIT_RET 4'hc
`define LIT_BANK 4'h1
`define LIT_MISC 4'h0
`define MISC_SLEEP 8'h03
`define MISC_PUSH 8'h05
`define MISC_POP 8'h06
`define MISC_IRET_HI 7'h08
`define MISC_TABLE_HI 5'h01
`define BANK_HI 4'h0
`define W_RESET 8'h00
`define BANK_RESET 4'h0
`define STATUS_RESET 5'h00
`define TBL_RESET 21'h000000
`define PC_RESET 21'h000000
`define TIMER0_COUNT_ADDR 8'hd6
`define PORT_ADDR_LO 8'h80
`define PORT_ADDR_HI 8'h84
`define MODE_NONE 2'h0
`define MODE_POST_INC 2'h1
`define MODE_POST_DEC 2'h2
`define MODE_PRE_INC 2'h3
`endif

// *** shared/core_decode_pkg.sv ***
/*
 Types shared by the decoder modules: operation classes, sequencer states and
 the flag bundle. Assumes the params header lies on the include path.
*/
package core_decode_pkg;
  typedef enum logic [4:0] {
    op_nop = 5'h00, op_bit_clear = 5'h01, op_bit_set = 5'h02, op_bit_toggle = 5'h03,
    op_skip_clear = 5'h04, op_skip_set = 5'h05, op_cond_branch = 5'h06, op_rel_jump = 5'h07,
    op_rel_call = 5'h08, op_abs_jump = 5'h09, op_abs_call = 5'h0a, op_irq_return = 5'h0b,
    op_const_return = 5'h0c, op_push = 5'h0d, op_pop = 5'h0e, op_sleep = 5'h0f,
    op_const_add = 5'h10, op_const_sub = 5'h11, op_const_and = 5'h12, op_const_or = 5'h13,
    op_const_xor = 5'h14, op_const_load = 5'h15, op_const_mul = 5'h16, op_bank_load = 5'h17,
    op_ptr_load = 5'h18, op_table_read = 5'h19, op_table_write = 5'h1a
  } op_class_t;
  typedef enum logic [1:0] {
    st_exec = 2'b00,
    st_flush = 2'b01,
    st_second = 2'b10,
    st_skip2 = 2'b11
  } seq_state_t;
  typedef struct packed {
    logic negative;
    logic overflow;
    logic zero;
    logic digit_carry;
    logic carry;
  } alu_flags_t;
endpackage

// *** verification/instr_decode_checker.sv ***
/*
 Port-level checker for the decoder: relations between fetched words and
 the decoder outputs. Bound into instr_decode_core by the bind at the foot.
*/
`timescale 1ns/1ps
module instr_decode_checker
#(
  parameter int PC_W = 21
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [PC_W-1:0] fetch_addr,
  input wire logic [15:0] fetch_word,
  input wire logic [7:0] file_rdata,
  input wire logic file_we,
  input wire logic [7:0] file_wdata,
  input wire logic prescaler_assigned,
  input wire logic prescaler_clear,
  input wire logic [7:0] working_register,
  input wire logic [3:0] bank_select_register,
  input wire core_decode_pkg::alu_flags_t status_flags,
  input wire logic [1:0] ptr_sel,
  input wire logic [11:0] ptr_value,
  input wire logic ptr_we,
  input wire logic table_rd,
  input wire logic table_wr,
  input wire logic mem_write_busy,
  input wire logic global_high_irq_enable,
  input wire logic peripheral_low_irq_enable,
  input wire logic standby,
  input wire logic timeout_flag,
  input wire logic powerdown_flag
);
  import core_decode_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_sleep_word;
    $past(fetch_word) == 16'h0003;
  endsequence
  sequence s_sleep_flags;
    timeout_flag && !powerdown_flag;
  endsequence
  property p_bit_write;
    file_we |-> fetch_word[15:12] inside {4'h9, 4'h8, 4'h7};
  endproperty
  a_bit_write: assert property (p_bit_write) else $error("bit write from wrong word");
  property p_clear_value;
    file_we && fetch_word[15:12] == 4'h9 && !fetch_word[8] |-> file_wdata == (file_rdata & ~(8'h01 << fetch_word[11:9]));
  endproperty
  a_clear_value: assert property (p_clear_value) else $error("bit clear value wrong");
  property p_prescaler;
    prescaler_clear |-> file_we && fetch_word[8:0] == 9'h1d6 && prescaler_assigned;
  endproperty
  a_prescaler: assert property (p_prescaler) else $error("prescaler clear without cause");
  property p_bank;
    $changed(bank_select_register) |-> $past(fetch_word[15:4]) == 12'h010 && bank_select_register == $past(fetch_word[3:0]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank change wrong");
  property p_logic_flags;
    fetch_word[15:8] inside {8'h0b, 8'h09, 8'h0a} |=> $stable({status_flags.carry, status_flags.digit_carry, status_flags.overflow});
  endproperty
  a_logic_flags: assert property (p_logic_flags) else $error("logic op touched carry or overflow");
  property p_flags_hold;
    fetch_word[15:12] != 4'h0 |=> $stable(status_flags);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flags changed by bit or control op");
  property p_no_flag_lit;
    fetch_word[15:8] inside {8'h0e, 8'h0d, 8'h0c, 8'h00, 8'h01} |=> $stable(status_flags);
  endproperty
  a_no_flag_lit: assert property (p_no_flag_lit) else $error("flags changed by flagless op");
  property p_sleep;
    $rose(standby) |-> s_sleep_word ##0 s_sleep_flags;
  endproperty
  a_sleep: assert property (p_sleep) else $error("standby entry wrong");
  property p_standby_hold;
    standby |=> standby && $stable(working_register) && $stable(fetch_addr);
  endproperty
  a_standby_hold: assert property (p_standby_hold) else $error("activity in standby");
  property p_ptr_load;
    ptr_we |-> $past(fetch_word[15:6]) == 10'h3b8 && ptr_sel == $past(fetch_word[5:4])
      && ptr_value == {$past(fetch_word[3:0]), fetch_word[7:0]};
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer load wrong");
  property p_irq_return;
    $rose(global_high_irq_enable) |-> $past(fetch_word[15:1]) == 15'h0008 && peripheral_low_irq_enable;
  endproperty
  a_irq_return: assert property (p_irq_return) else $error("enable rise wrong");
  property p_table;
    (table_rd |-> fetch_word[15:2] == 14'h0002) and (table_wr |-> fetch_word[15:2] == 14'h0003);
  endproperty
  a_table: assert property (p_table) else $error("table strobe from wrong word");
  property p_stall;
    mem_write_busy && fetch_word[15:2] == 14'h0003 && $past(fetch_word[15:13]) != 3'b101 |=> $stable(fetch_addr);
  endproperty
  a_stall: assert property (p_stall) else $error("pc moved during busy write");
endmodule

bind instr_decode_core instr_decode_checker #(.PC_W(PC_W)) i_checker (.clk, .reset, .fetch_addr, .fetch_word,
  .file_rdata, .file_we, .file_wdata, .prescaler_assigned, .prescaler_clear, .working_register,
  .bank_select_register, .status_flags, .ptr_sel, .ptr_value, .ptr_we, .table_rd, .table_wr, .mem_write_busy,
  .global_high_irq_enable, .peripheral_low_irq_enable, .standby, .timeout_flag, .powerdown_flag);

// *** verification/prog_mem.sv ***
/*
 Program memory model: 64 words, read combinationally at the fetch address.
 Assumes the bench fills mem through hierarchical writes before each run.
*/
`timescale 1ns/1ps
module prog_mem
#(
  parameter int PC_W = 21
)
(
  input wire logic [PC_W-1:0] addr,
  output logic [15:0] word
);
  logic [15:0] mem [64];
  // Space past the array reads as no-op words
  assign word = (addr < 64) ? mem[addr[5:0]] : 16'h0000;
endmodule

// *** verification/testbench.sv ***
/*
 Self-checking bench: resets, loads short programs into the memory model,
 steps the core and compares outputs. Assumes a 10 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
  import core_decode_pkg::*;
  localparam int PC_W = 21;
  logic clk, reset, file_we, prescaler_assigned, prescaler_clear, ptr_we, table_rd, table_wr, mem_write_busy;
  logic global_high_irq_enable, peripheral_low_irq_enable, standby, timeout_flag, powerdown_flag, context_restore;
  logic [PC_W-1:0] fetch_addr, table_ptr, stack_top;
  logic [15:0] fetch_word, product;
  logic [7:0] file_rdata, pin_levels, file_wdata, working_register;
  logic [3:0] bank_select_register;
  logic [1:0] ptr_sel;
  logic [11:0] ptr_value;
  alu_flags_t status_flags;
  int fails = 0;
  int compares = 0;

  prog_mem #(.PC_W(PC_W)) i_mem (.addr(fetch_addr), .word(fetch_word));
  instr_decode_core #(.PC_W(PC_W), .STACK_DEPTH(31)) i_dut (.clk, .reset, .fetch_addr, .fetch_word,
    .file_addr(), .file_access_bank(), .file_rdata, .pin_levels, .file_we, .file_wdata, .prescaler_assigned,
    .prescaler_clear, .working_register, .bank_select_register, .status_flags, .ptr_sel, .ptr_value, .ptr_we,
    .table_ptr, .table_rd, .table_wr, .mem_write_busy, .stack_top, .context_save(), .context_restore,
    .global_high_irq_enable, .peripheral_low_irq_enable, .product, .standby, .timeout_flag, .powerdown_flag);

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Memory cleared while the old program still runs; harmless under reset
  task automatic start(input int n, input logic [7:0] rd, input logic [7:0] pins, input logic pre, input logic busy);
    for (int a = 0; a < 64; a++)
      i_mem.mem[a] = 16'h0000;
    @(posedge clk);
    reset <= 1'b1;
    file_rdata <= rd;
    pin_levels <= pins;
    prescaler_assigned <= pre;
    mem_write_busy <= busy;
    repeat (n) @(posedge clk);
    reset <= 1'b0;
    #1;
  endtask

  task automatic load(input int at, input logic [15:0] ws[$]);
    foreach (ws[i])
      i_mem.mem[at + i] = ws[i];
    #1;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_w(input logic [7:0] v, input int lim);
    for (int i = 0; i < lim && working_register !== v; i++)
      step(1);
    if (working_register !== v)
    begin
      fails++;
      test_done();
    end
  endtask

  initial
  begin
    logic tk;
    logic [7:0] ew [8];
    logic [4:0] ef [8];
    logic [7:0] eb [4];
    reset = 1'b1;
    file_rdata = 8'h00;
    pin_levels = 8'h00;
    prescaler_assigned = 1'b0;
    mem_write_busy = 1'b0;
    ew = '{8'h25, 8'h35, 8'h05, 8'h35, 8'h00, 8'h80, 8'h80, 8'h7f};
    ef = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h04, 5'h04, 5'h04, 5'h03};
    eb = '{8'h58, 8'h5e, 8'h0e, 8'h5b};
    start(20, 8'h00, 8'h00, 1'b0, 1'b0);
    check(timeout_flag, 1'b1);
    check(powerdown_flag, 1'b1);
    load(0, '{16'h0e25, 16'h0f10, 16'h0b0f, 16'h0930, 16'h0a35, 16'h0e80, 16'h0d02, 16'h08ff, 16'h0107});
    foreach (ew[i])
    begin
      step(1);
      check(working_register, ew[i]);
      check(status_flags, ef[i]);
    end
    step(1);
    check(bank_select_register, 4'h7);
    check(product, 16'h0100);
    check(fetch_addr, 21'h9);
    $display("literal test done");
    for (int c = 0; c < 8; c++)
    begin
      start(2, 8'h00, 8'h00, 1'b0, 1'b0);
      load(0, '{16'h0900, {5'b11100, 3'(c), 8'h02}, 16'h0e66});
      load(6, '{16'h0e55});
      tk = (c == 0) || (c == 3) || (c == 5) || (c == 7);
      step(2);
      check(fetch_addr, tk ? 21'h6 : 21'h2);
      step(1);
      check(working_register, tk ? 8'h00 : 8'h66);
      step(1);
      check(working_register, tk ? 8'h55 : 8'h66);
    end
    $display("branch test done");
    start(2, 8'h00, 8'h00, 1'b0, 1'b0);
    load(0, '{16'hd802, 16'hd806, 16'h0e77});
    load(5, '{16'h0c42});
    load(14, '{16'h0011});
    step(1);
    check(fetch_addr, 21'h5);
    check(stack_top, 21'h1);
    step(2);
    check(working_register, 8'h42);
    check(fetch_addr, 21'h1);
    step(2);
    check(fetch_addr, 21'he);
    check(stack_top, 21'h2);
    step(1);
    check(context_restore, 1'b1);
    step(1);
    check(global_high_irq_enable, 1'b1);
    check(peripheral_low_irq_enable, 1'b1);
    check(fetch_addr, 21'h2);
    step(1);
    check(working_register, 8'h42);
    step(1);
    check(working_register, 8'h77);
    $display("call test done");
    start(2, 8'h04, 8'h00, 1'b0, 1'b0);
    load(0, '{16'hb410, 16'h0e11, 16'ha410, 16'hef00, 16'hf000, 16'h0e33});
    step(2);
    check(working_register, 8'h11);
    step(3);
    check(working_register, 8'h11);
    step(1);
    check(working_register, 8'h33);
    check(status_flags, 5'h00);
    $display("skip test done");
    start(2, 8'h5a, 8'h0f, 1'b1, 1'b0);
    load(0, '{16'h9210, 16'h8410, 16'h7182, 16'h81d6, 16'hf0ff, 16'hee25, 16'hf0ab, 16'h0e12});
    for (int i = 0; i < 4; i++)
    begin
      check(file_we, 1'b1);
      check(file_wdata, eb[i]);
      check(prescaler_clear, i == 3);
      step(1);
    end
    check(file_we, 1'b0);
    step(2);
    check(ptr_we, 1'b1);
    check(ptr_sel, 2'h2);
    check(ptr_value, 12'h5ab);
    step(2);
    check(working_register, 8'h12);
    $display("bit and pointer test done");
    start(2, 8'h00, 8'h00, 1'b0, 1'b0);
    load(0, '{16'h0005, 16'h0006, 16'h0e44, 16'h0003, 16'h0e99});
    step(3);
    check(working_register, 8'h44);
    step(1);
    check(standby, 1'b1);
    check(timeout_flag, 1'b1);
    check(powerdown_flag, 1'b0);
    step(2);
    check(working_register, 8'h44);
    $display("stack and sleep test done");
    start(2, 8'h00, 8'h00, 1'b0, 1'b1);
    load(0, '{16'h0009, 16'h000b, 16'h000e, 16'h0e5a});
    check(table_rd, 1'b1);
    check(table_ptr, 21'h0);
    step(2);
    check(table_ptr, 21'h2);
    step(2);
    check(table_wr, 1'b0);
    step(3);
    check(fetch_addr, 21'h2);
    @(posedge clk) mem_write_busy <= 1'b0;
    #1;
    check(table_wr, 1'b1);
    wait_w(8'h5a, 8);
    check(table_ptr, 21'h1);
    $display("table test done");
    test_done();
  end
endmodule
